// *** design/aqe_defines.svh ***
/*
   Constants for the quadrature encoder counter: filter length, fraction
   widths, decimal modulus and reset values.
   Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef AQE_DEFINES_SVH
`define AQE_DEFINES_SVH

// Spike filter: an input level must persist this many clocks to pass
`define AQE_FILT_CYC      2'h3
`define AQE_FILT_LAST     2'h2
`define AQE_FILT_ZERO     2'h0

// Accumulator layout
`define AQE_INT_W         32
`define AQE_FRAC_W        16
`define AQE_CONST_W       32
`define AQE_CONST_INT_MSB 31
`define AQE_CONST_INT_LSB 16
`define AQE_CONST_FRAC_MSB 15

// Decimal fraction wraps at ten thousand
`define AQE_DEC_MOD       17'h0_2710

// Reset values
`define AQE_POS_ZERO      32'h0000_0000
`define AQE_FRAC_ZERO     16'h0000

`endif

// *** design/aqe_pkg.sv ***
/*
   Types shared by the quadrature encoder counter modules.
   Assumes aqe_defines.svh is on the include path.
*/
`include "aqe_defines.svh"

package aqe_pkg;

   // One quadrature decode result per clock
   typedef enum logic [2:0]
   {
      AQE_STEP_NONE = 3'b001,
      AQE_STEP_UP   = 3'b010,
      AQE_STEP_DOWN = 3'b100
   } aqe_step_t;

   typedef logic [`AQE_INT_W-1:0]  aqe_pos_t;
   typedef logic [`AQE_FRAC_W-1:0] aqe_frac_t;

endpackage : aqe_pkg

// *** design/aqe_spike_filter.sv ***
/*
   Two-stage synchroniser followed by a digital spike filter for one encoder
   input. The output follows the pin only after the synchronised level has
   differed from it for three consecutive clocks.
   Assumes a single clock MCLK domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aqe_defines.svh"

module aqe_spike_filter
   import aqe_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Raw pin and filtered level
   input  wire logic pin,
   output var  logic filt
);

   logic       sync1;
   logic       sync2;
   logic [1:0] run_cnt;

   // Only sync2 reads sync1, metastability stays inside the pair
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end
      else
      begin
         sync1 <= pin;
         sync2 <= sync1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         run_cnt <= `AQE_FILT_ZERO;
         filt    <= 1'b0;
      end
      else if (sync2 == filt)
      begin
         run_cnt <= `AQE_FILT_ZERO;
      end
      else if (run_cnt == `AQE_FILT_LAST)
      begin
         run_cnt <= `AQE_FILT_ZERO;
         filt    <= sync2; // see R19
      end
      else
      begin
         run_cnt <= run_cnt + 2'h1;
      end
   end

   property p_spike_reject;
      @(posedge clk) disable iff (rst)
      $changed(filt) |-> ($past(sync2, 1) == filt) && ($past(sync2, 2) == filt)
                         && ($past(sync2, 3) == filt);
   endproperty
   a_spike_reject: assert property (p_spike_reject) // see R19
      else $error("Filter output changed before three stable clocks");

endmodule : aqe_spike_filter

`default_nettype wire

// *** design/aqe_counter.sv ***
/*
   Incremental ABN quadrature encoder counter: filtered A/B/N inputs, a
   signed 16.16 encoder constant in binary or decimal fraction mode, index
   driven clear and latch, a clear-on-read event flag and an interrupt.
   Assumes one 50 MHz clock MCLK, synchronous reset SRST, and that the
   configuration ports are driven from logic on MCLK.
*/
// Functional notes
// R1: Accepted index event clears or snapshots the position, by configuration.
// R2: Continuous index flag acts on every accepted index event.
// R3: Single-shot flag acts on the next accepted index, then disarms itself.
// R4: Index accepted only while A and B sit at the selected levels.
// R5: Position cleared on index only with clear-enable and once or continuous set.
// R6: Each A or B polarity change adds or subtracts the constant by direction.
// R7: Constant is signed 16.16 fixed point, two's complement in binary mode.
// R8: Decimal mode reads the constant's low half as 0 to 9999.
// R9: Software encodes negative decimal constants as (2^16-(int+1)).(10000-dec).
// R10: A negative constant reverses the counting direction.
// R11: Current integer position is always readable on a counter output.
// R12: A, B and index levels are selectable active high or active low.
// R13: Event flag set whenever an index clear or latch takes place.
// R14: Index event copies the position into a separate latch output.
// R15: Latch holds zero after reset until the first index event.
// R16: Index latch event asserts the interrupt output.
// R17: Status read clears the flag; a coinciding event is lost.
// R18: Encoder edges stay below two thirds of the clock rate.
// R19: A, B and index filters reject pulses shorter than three clocks.
// R20: Global configuration selects whether the shared pins serve the encoder.
// R21: Counting works with the index input unused.
// R22: Decimal fraction wraps at 10000, binary at 2^16, carrying into integer.
// R23: Direction decoded from A/B phase; only the integer part is exposed.
`timescale 1ns/100ps
`default_nettype none
`include "aqe_defines.svh"
module aqe_counter
   import aqe_pkg::*;
(
   // Clock and reset
   input  wire logic                    MCLK,
   input  wire logic                    SRST,
   // Encoder pins
   input  wire logic                    ENC_A,
   input  wire logic                    ENC_B,
   input  wire logic                    ENC_N,
   // global_config: pins serve the encoder
   input  wire logic                    ENC_PIN_SEL,
   // encoder_mode_config
   input  wire logic                    POL_A,
   input  wire logic                    POL_B,
   input  wire logic                    POL_N,
   input  wire logic                    CLR_CONT,
   input  wire logic                    CLR_ONCE,
   input  wire logic                    CLR_ENC_X,
   input  wire logic                    DEC_MODE,
   input  wire logic [`AQE_CONST_W-1:0] ENC_CONST,
   // Status access
   input  wire logic                    STATUS_RD,
   // Results
   output var  logic [`AQE_INT_W-1:0]   X_ENC,
   output var  logic [`AQE_INT_W-1:0]   ENC_LATCH,
   output var  logic                    EVENT_FLAG,
   output var  logic                    IRQ
);

   logic      a_f;
   logic      b_f;
   logic      n_f;
   logic      a_prev;
   logic      b_prev;
   logic      n_act_prev;
   logic      n_act;
   logic      idx_ok;
   logic      idx_act;
   logic      armed;
   logic      once_prev;
   aqe_frac_t pos_frac;
   aqe_step_t step;
   aqe_pos_t  const_int;
   aqe_frac_t const_frac;
   aqe_pos_t  next_int;
   aqe_frac_t next_frac;
   logic [`AQE_INT_W+`AQE_FRAC_W-1:0] bin_sum;
   logic [`AQE_FRAC_W:0]              dec_tmp;
   logic                              dec_carry;

   // One filter per encoder input
   logic [2:0] pin_vec;
   logic [2:0] filt_vec;
   assign pin_vec = {ENC_N, ENC_B, ENC_A};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_filt
         aqe_spike_filter u_filt
         (
            .clk  (MCLK),
            .rst  (SRST),
            .pin  (pin_vec[gi]),
            .filt (filt_vec[gi])
         ); // see R19
      end
   endgenerate

   assign a_f = filt_vec[0];
   assign b_f = filt_vec[1];
   assign n_f = filt_vec[2];
   // Index active level chosen by POL_N
   assign n_act = (n_f == POL_N); // see R12

   // Previous filtered levels for edge and phase decode
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         a_prev     <= 1'b0;
         b_prev     <= 1'b0;
         n_act_prev <= 1'b1;
      end
      else
      begin
         a_prev     <= a_f;
         b_prev     <= b_f;
         n_act_prev <= n_act;
      end
   end

   // Pins shared with other functions are ignored unless selected
   always_comb
   begin
      step = AQE_STEP_NONE;
      if (ENC_PIN_SEL) // see R20
      begin
         if ((a_f != a_prev) && (b_f == b_prev))
         begin
            step = (a_f != b_f) ? AQE_STEP_UP : AQE_STEP_DOWN; // see R23
         end
         else if ((b_f != b_prev) && (a_f == a_prev))
         begin
            step = (a_f == b_f) ? AQE_STEP_UP : AQE_STEP_DOWN; // see R23
         end
      end
   end

   // Index accepted on its active edge while A and B are at the chosen levels
   assign idx_ok  = ENC_PIN_SEL && n_act && !n_act_prev
                    && (a_f == POL_A) && (b_f == POL_B); // see R4
   assign idx_act = idx_ok && (CLR_CONT || armed); // see R1 R2 R3

   // Single shot arms on a rising CLR_ONCE and disarms after one event taken with CLR_CONT low
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         once_prev <= 1'b0;
         armed     <= 1'b0;
      end
      else
      begin
         once_prev <= CLR_ONCE;
         if (idx_act && !CLR_CONT)
         begin
            armed <= 1'b0; // see R3
         end
         else if (CLR_ONCE && !once_prev)
         begin
            armed <= 1'b1;
         end
      end
   end

   // Constant split into signed integer and fraction
   assign const_int  = {{`AQE_FRAC_W{ENC_CONST[`AQE_CONST_INT_MSB]}},
                        ENC_CONST[`AQE_CONST_INT_MSB:`AQE_CONST_INT_LSB]}; // see R7
   assign const_frac = ENC_CONST[`AQE_CONST_FRAC_MSB:0];

   // Sign of the constant alone sets the direction, no extra inversion
   always_comb
   begin
      next_int  = X_ENC;
      next_frac = pos_frac;
      bin_sum   = {X_ENC, pos_frac};
      dec_tmp   = {1'b0, pos_frac};
      dec_carry = 1'b0;
      if (step == AQE_STEP_UP)
      begin
         if (!DEC_MODE)
         begin
            bin_sum   = {X_ENC, pos_frac} + {const_int, const_frac}; // see R6 R10
            next_int  = bin_sum[`AQE_INT_W+`AQE_FRAC_W-1:`AQE_FRAC_W];
            next_frac = bin_sum[`AQE_FRAC_W-1:0];
         end
         else
         begin
            dec_tmp = {1'b0, pos_frac} + {1'b0, const_frac}; // see R8
            if (dec_tmp >= `AQE_DEC_MOD)
            begin
               dec_tmp   = dec_tmp - `AQE_DEC_MOD; // see R22
               dec_carry = 1'b1;
            end
            next_frac = dec_tmp[`AQE_FRAC_W-1:0];
            next_int  = X_ENC + const_int + {{(`AQE_INT_W-1){1'b0}}, dec_carry};
         end
      end
      else if (step == AQE_STEP_DOWN)
      begin
         if (!DEC_MODE)
         begin
            bin_sum   = {X_ENC, pos_frac} - {const_int, const_frac}; // see R6 R10
            next_int  = bin_sum[`AQE_INT_W+`AQE_FRAC_W-1:`AQE_FRAC_W];
            next_frac = bin_sum[`AQE_FRAC_W-1:0];
         end
         else
         begin
            dec_tmp = {1'b0, pos_frac} - {1'b0, const_frac}; // see R8
            if (dec_tmp[`AQE_FRAC_W])
            begin
               dec_tmp   = dec_tmp + `AQE_DEC_MOD; // see R22
               dec_carry = 1'b1;
            end
            next_frac = dec_tmp[`AQE_FRAC_W-1:0];
            next_int  = X_ENC - const_int - {{(`AQE_INT_W-1){1'b0}}, dec_carry};
         end
      end
   end

   // Accumulator; an index clear overrides a step in the same clock
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         X_ENC    <= `AQE_POS_ZERO;
         pos_frac <= `AQE_FRAC_ZERO;
      end
      else if (idx_act && CLR_ENC_X)
      begin
         X_ENC    <= `AQE_POS_ZERO; // see R5
         pos_frac <= `AQE_FRAC_ZERO;
      end
      else
      begin
         X_ENC    <= next_int; // see R11 R21
         pos_frac <= next_frac;
      end
   end

   // Snapshot of the position as it stood before any clear
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         ENC_LATCH <= `AQE_POS_ZERO; // see R15
      end
      else if (idx_act)
      begin
         ENC_LATCH <= X_ENC; // see R14
      end
   end

   // The read clear wins over a coinciding event, so polling can lose one
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         EVENT_FLAG <= 1'b0;
         IRQ        <= 1'b0;
      end
      else if (STATUS_RD)
      begin
         EVENT_FLAG <= 1'b0; // see R17
         IRQ        <= 1'b0; // see R17
      end
      else if (idx_act)
      begin
         EVENT_FLAG <= 1'b1; // see R13
         IRQ        <= 1'b1; // see R16
      end
   end

   property p_latch_copy;
      @(posedge MCLK) disable iff (SRST)
      idx_act |=> (ENC_LATCH == $past(X_ENC));
   endproperty
   a_latch_copy: assert property (p_latch_copy) // see R14
      else $error("Latch did not capture the position on index");

   property p_index_clear;
      @(posedge MCLK) disable iff (SRST)
      (idx_act && CLR_ENC_X) |=> (X_ENC == `AQE_POS_ZERO) && (pos_frac == `AQE_FRAC_ZERO);
   endproperty
   a_index_clear: assert property (p_index_clear) // see R5
      else $error("Position not cleared on index");

   property p_idle_index;
      @(posedge MCLK) disable iff (SRST)
      (idx_ok && !CLR_CONT && !armed && step == AQE_STEP_NONE)
      |=> $stable(X_ENC) && $stable(ENC_LATCH) && $stable(pos_frac);
   endproperty
   a_idle_index: assert property (p_idle_index) // see R3
      else $error("Index acted while neither armed nor continuous");

   property p_once_disarm;
      @(posedge MCLK) disable iff (SRST)
      (idx_act && !CLR_CONT) |=> !armed;
   endproperty
   a_once_disarm: assert property (p_once_disarm) // see R3
      else $error("Single shot did not disarm");

   property p_cont_every;
      @(posedge MCLK) disable iff (SRST)
      (CLR_CONT && idx_ok) |=> (ENC_LATCH == $past(X_ENC));
   endproperty
   a_cont_every: assert property (p_cont_every) // see R2
      else $error("Continuous mode skipped an index");

   property p_qualifier;
      @(posedge MCLK) disable iff (SRST)
      idx_act |-> (a_f == POL_A) && (b_f == POL_B) && ENC_PIN_SEL;
   endproperty
   a_qualifier: assert property (p_qualifier) // see R4
      else $error("Index accepted outside the A/B window");

   property p_flag_irq;
      @(posedge MCLK) disable iff (SRST)
      (idx_act && !STATUS_RD) |=> EVENT_FLAG && IRQ;
   endproperty
   a_flag_irq: assert property (p_flag_irq) // see R13 R16
      else $error("Index event did not raise flag and interrupt");

   property p_read_clear;
      @(posedge MCLK) disable iff (SRST)
      STATUS_RD |=> !EVENT_FLAG && !IRQ;
   endproperty
   a_read_clear: assert property (p_read_clear) // see R17
      else $error("Status read did not clear the flag");

   property p_bin_up;
      @(posedge MCLK) disable iff (SRST)
      (step == AQE_STEP_UP && !DEC_MODE && !idx_act)
      |=> ({X_ENC, pos_frac} == $past({X_ENC, pos_frac}) + $past({const_int, const_frac}));
   endproperty
   a_bin_up: assert property (p_bin_up) // see R6 R7
      else $error("Binary step did not add the constant");

   property p_dec_range;
      @(posedge MCLK) disable iff (SRST)
      (DEC_MODE && {1'b0, pos_frac} < `AQE_DEC_MOD && {1'b0, const_frac} < `AQE_DEC_MOD)
      |=> ({1'b0, pos_frac} < `AQE_DEC_MOD);
   endproperty
   a_dec_range: assert property (p_dec_range) // see R22
      else $error("Decimal fraction left its range");

   property p_pins_off;
      @(posedge MCLK) disable iff (SRST)
      !ENC_PIN_SEL |=> $stable(X_ENC) && $stable(ENC_LATCH);
   endproperty
   a_pins_off: assert property (p_pins_off) // see R20
      else $error("Counter moved while pins are deselected");

   c_step_up:    cover property (@(posedge MCLK) disable iff (SRST) step == AQE_STEP_UP);
   c_step_down:  cover property (@(posedge MCLK) disable iff (SRST) step == AQE_STEP_DOWN);
   c_idx_clear:  cover property (@(posedge MCLK) disable iff (SRST) idx_act && CLR_ENC_X);
   c_once_done:  cover property (@(posedge MCLK) disable iff (SRST)
                                 idx_act && !CLR_CONT ##1 !armed);

endmodule : aqe_counter

`default_nettype wire

// *** verif/aqe_enc_model.sv ***
/*
   Behavioural incremental encoder: quadrature A/B steps, index pulses and
   short spikes, all driven just after the falling edge of the clock.
   Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/100ps
`default_nettype none

module aqe_enc_model
(
   // Clock and index polarity
   input  wire logic clk,
   input  wire logic pol_n,
   // Encoder pins
   output var  logic enc_a,
   output var  logic enc_b,
   output wire logic enc_n
);
   logic n_act;

   initial
   begin
      enc_a = 1'b0;
      enc_b = 1'b0;
      n_act = 1'b0;
   end

   // Index idles at its inactive level
   assign enc_n = ~(n_act ^ pol_n);

   // One x4 step; each level held six clocks, below 2/3 of the clock rate
   task automatic step(input logic up);
      @(negedge clk);
      if (up == (enc_a == enc_b))
         enc_a = ~enc_a;
      else
         enc_b = ~enc_b;
      repeat (5) @(negedge clk);
   endtask : step

   task automatic index();
      @(negedge clk);
      n_act = 1'b1;
      repeat (6) @(negedge clk);
      n_act = 1'b0;
      repeat (10) @(negedge clk);
   endtask : index

   // Pulse of len clocks on A (or on the index when on_n is set)
   task automatic spike(input logic on_n, input int len);
      @(negedge clk);
      if (on_n)
         n_act = 1'b1;
      else
         enc_a = ~enc_a;
      repeat (len) @(negedge clk);
      if (on_n)
         n_act = 1'b0;
      else
         enc_a = ~enc_a;
      repeat (10) @(negedge clk);
   endtask : spike

endmodule : aqe_enc_model

`default_nettype wire

// *** verif/aqe_counter_tb_top.sv ***
/*
   Self-checking bench for the quadrature encoder counter.
   Assumes the encoder model drives the pins; config changes at falling edges.
*/
`timescale 1ns/100ps
`default_nettype none

module aqe_counter_tb_top
   import aqe_pkg::*;
;
   logic        MCLK = 1'b0;
   logic        SRST = 1'b1;
   logic        ENC_A, ENC_B, ENC_N;
   logic        ENC_PIN_SEL = 1'b1;
   logic        POL_A = 1'b0;
   logic        POL_B = 1'b0;
   logic        POL_N = 1'b1;
   logic        CLR_CONT = 1'b0;
   logic        CLR_ONCE = 1'b0;
   logic        CLR_ENC_X = 1'b0;
   logic        DEC_MODE = 1'b0;
   logic [31:0] ENC_CONST = 32'h0001_0000;
   logic        STATUS_RD = 1'b0;
   aqe_pos_t    X_ENC, ENC_LATCH;
   logic        EVENT_FLAG, IRQ;
   int          bad_count = 0;
   int          n_compared = 0;
   int          cycles = 0;

   always #10 MCLK = ~MCLK;

   aqe_enc_model aqe_enc_model_i (.clk(MCLK), .pol_n(POL_N), .enc_a(ENC_A), .enc_b(ENC_B),
      .enc_n(ENC_N));

   aqe_counter aqe_counter_i (.MCLK(MCLK), .SRST(SRST), .ENC_A(ENC_A), .ENC_B(ENC_B),
      .ENC_N(ENC_N), .ENC_PIN_SEL(ENC_PIN_SEL), .POL_A(POL_A), .POL_B(POL_B), .POL_N(POL_N),
      .CLR_CONT(CLR_CONT), .CLR_ONCE(CLR_ONCE), .CLR_ENC_X(CLR_ENC_X), .DEC_MODE(DEC_MODE),
      .ENC_CONST(ENC_CONST), .STATUS_RD(STATUS_RD), .X_ENC(X_ENC), .ENC_LATCH(ENC_LATCH),
      .EVENT_FLAG(EVENT_FLAG), .IRQ(IRQ));

   task automatic results();
      if (bad_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Several steps, then time for the pipeline to settle
   task automatic steps(input logic up, input int n);
      repeat (n) aqe_enc_model_i.step(up);
      repeat (10) @(negedge MCLK);
   endtask : steps

   task automatic status_read();
      @(negedge MCLK);
      STATUS_RD = 1'b1;
      @(negedge MCLK);
      STATUS_RD = 1'b0;
      repeat (2) @(negedge MCLK);
   endtask : status_read

   // Index event, then position, snapshot and both event outputs
   task automatic idx_check(input logic [31:0] x, input logic [31:0] lat, input logic ev);
      aqe_enc_model_i.index();
      check(X_ENC, x);
      check(ENC_LATCH, lat);
      check({31'h0, EVENT_FLAG}, {31'h0, ev});
      check({31'h0, IRQ}, {31'h0, ev});
   endtask : idx_check

   task automatic t_counting();
      steps(1'b1, 4);
      check(X_ENC, 32'h0000_0004);
      aqe_enc_model_i.spike(1'b0, 2);
      check(X_ENC, 32'h0000_0004);
      steps(1'b0, 4);
      check(X_ENC, 32'h0000_0000);
      ENC_CONST = 32'hFFFF_0000;
      steps(1'b1, 4);
      check(X_ENC, 32'hFFFF_FFFC);
      steps(1'b0, 4);
      ENC_CONST = 32'h0000_8000;
      steps(1'b1, 2);
      check(X_ENC, 32'h0000_0001);
      steps(1'b0, 2);
      check(X_ENC, 32'h0000_0000);
   endtask : t_counting

   task automatic t_decimal();
      DEC_MODE = 1'b1;
      ENC_CONST = 32'h0000_1388;
      steps(1'b1, 2);
      check(X_ENC, 32'h0000_0001);
      steps(1'b0, 2);
      ENC_CONST = 32'hFFE6_0FA0; // Minus 25.6
      steps(1'b1, 2);
      check(X_ENC, 32'hFFFF_FFCC);
      steps(1'b0, 2);
      check(X_ENC, 32'h0000_0000);
      DEC_MODE = 1'b0;
   endtask : t_decimal

   task automatic t_index();
      ENC_CONST = 32'h0003_0000;
      steps(1'b1, 4);
      CLR_CONT = 1'b1;
      aqe_enc_model_i.spike(1'b1, 2);
      check({31'h0, EVENT_FLAG}, 32'h0);
      idx_check(32'h0000_000C, 32'h0000_000C, 1'b1);
      status_read();
      check({31'h0, EVENT_FLAG}, 32'h0);
      check({31'h0, IRQ}, 32'h0);
      steps(1'b1, 4);
      idx_check(32'h0000_0018, 32'h0000_0018, 1'b1);
      status_read();
      CLR_CONT = 1'b0;
      CLR_ENC_X = 1'b1;
      idx_check(32'h0000_0018, 32'h0000_0018, 1'b0);
      CLR_ONCE = 1'b1;
      idx_check(32'h0000_0000, 32'h0000_0018, 1'b1);
      status_read();
      steps(1'b1, 4);
      idx_check(32'h0000_000C, 32'h0000_0018, 1'b0);
      CLR_ONCE = 1'b0;
   endtask : t_index

   task automatic t_gating();
      CLR_CONT = 1'b1;
      POL_A = 1'b1;
      idx_check(32'h0000_000C, 32'h0000_0018, 1'b0);
      steps(1'b1, 2);
      POL_B = 1'b1;
      idx_check(32'h0000_0000, 32'h0000_0012, 1'b1);
      status_read();
      // Index polarity flipped with the action off, so the swap is not an event
      CLR_CONT = 1'b0;
      POL_N = 1'b0;
      // The next up step leaves A low and B high, so the window must follow
      POL_A = 1'b0;
      repeat (12) @(negedge MCLK);
      CLR_CONT = 1'b1;
      steps(1'b1, 1);
      idx_check(32'h0000_0000, 32'h0000_0003, 1'b1);
      status_read();
      ENC_PIN_SEL = 1'b0;
      steps(1'b1, 4);
      check(X_ENC, 32'h0000_0000);
      idx_check(32'h0000_0000, 32'h0000_0003, 1'b0);
      ENC_PIN_SEL = 1'b1;
      CLR_CONT = 1'b0;
      steps(1'b0, 1);
      check(X_ENC, 32'hFFFF_FFFD);
   endtask : t_gating

   // Hang guard: the whole run needs well under this many clocks
   always @(posedge MCLK)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         bad_count++;
         results();
      end
   end

   initial
   begin
      repeat (16) @(negedge MCLK);
      SRST = 1'b0;
      repeat (2) @(negedge MCLK);
      check(X_ENC, 32'h0000_0000);
      check(ENC_LATCH, 32'h0000_0000);
      check({31'h0, EVENT_FLAG}, 32'h0);
      t_counting();
      t_decimal();
      t_index();
      t_gating();
      results();
   end

endmodule : aqe_counter_tb_top

`default_nettype wire
